// >>> hw/eqr_regs.sv
// Register bank for indirect access to the receive equalizer RAM and its voltage reference.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// (R1) Writing offset D8 loads bits 31 to 24 of the staging word.
// (R2) Writing offset D9 loads bits 23 to 16 of the staging word.
// (R3) Writing offset DA loads bits 15 to 8 of the staging word.
// (R4) Writing offset DB loads bits 7 to 0 of the staging word.
// (R5) Reading D8 to DB returns the top to bottom byte of the RAM word picked by the index register at FC.
// (R6) Writes only reach the staging word while reads show RAM contents.
// (R7) While the receive line hold is 1 the data and reference registers stay at reset.
// (R8) Software programs the reference field to 2C for T1 operation.
// (R9) Software programs the reference field to 34 for E1 operation.
// (R10) The reference field lives in bits 5 to 0 and bits 7 and 6 do nothing.
// (R11) The staging word enters the RAM only on a write command given through the index register block.
module eqr_regs
  import eqr_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Receive line hold from the line interface configuration.
  input  wire logic       receive_line_hold,
  // Equalizer reference to the analog front end.
  output logic      [5:0] equalizer_reference_field
);
  localparam int AW = 8;

  // Elaboration-time guard: the 8-bit index cannot serve more than 256 words.
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_depth_check
    $error("eqr_regs depth out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire hit_b3   = reg_addr == EQR_OFS_BYTE3;
  wire hit_b2   = reg_addr == EQR_OFS_BYTE2;
  wire hit_b1   = reg_addr == EQR_OFS_BYTE1;
  wire hit_b0   = reg_addr == EQR_OFS_BYTE0;
  wire hit_vref = reg_addr == EQR_OFS_VREF;
  wire hit_idx  = reg_addr == EQR_OFS_INDEX;
  wire hit_ctrl = reg_addr == EQR_OFS_CTRL;

  ////////////////////////////////////////////////////////////////////////////////
  // Staging word, reference and index.
  logic [31:0]           equalizer_ram_word_q;
  logic [EQR_VREF_W-1:0] vref_q;
  logic [AW-1:0]         index_q;
  logic                  commit_q;
  logic [31:0]           ram_rd;

  // Hold acts as a synchronous reset so the line side can clear without glitching the async tree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      equalizer_ram_word_q <= {4{EQR_RST_DATA}};
      vref_q               <= EQR_RST_VREF;
    end else if (receive_line_hold) begin // R7
      equalizer_ram_word_q <= {4{EQR_RST_DATA}};
      vref_q               <= EQR_RST_VREF;
    end else if (reg_wr) begin
      if (hit_b3) equalizer_ram_word_q[31:24] <= reg_wdata; // R1 R6
      if (hit_b2) equalizer_ram_word_q[23:16] <= reg_wdata; // R2 R6
      if (hit_b1) equalizer_ram_word_q[15:8]  <= reg_wdata; // R3 R6
      if (hit_b0) equalizer_ram_word_q[7:0]   <= reg_wdata; // R4 R6
      if (hit_vref) vref_q <= reg_wdata[EQR_VREF_W-1:0]; // R10
    end
  end

  // Index and commit strobe; the commit is a one-cycle pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_q  <= EQR_RST_INDEX;
      commit_q <= 1'b0;
    end else begin
      if (reg_wr && hit_idx) index_q <= reg_wdata;
      commit_q <= reg_wr && hit_ctrl && reg_wdata[EQR_CTRL_WR_BIT] && !receive_line_hold; // R11
    end
  end

  assign equalizer_reference_field = vref_q;

  ////////////////////////////////////////////////////////////////////////////////
  // RAM: written only by the commit pulse, read at the index.
  eqr_ram #(.DEPTH(DEPTH), .AW(AW), .DW(32)) u_ram (
    .clk       (clk),
    .wr_en     (commit_q), // R11
    .wr_addr   (index_q),
    .wr_data   (equalizer_ram_word_q),
    .rd_addr   (index_q),
    .rd_data_q (ram_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read path. Read data come back the cycle after the strobe. A read right
  // after an index change sees the old word, so software allows one idle cycle.
  logic [7:0] rd_sel;
  logic [7:0] rdata_q;
  wire  [7:0] ctrl_rd = {6'h00, commit_q, 1'b0};
  assign rd_sel = hit_b3   ? ram_rd[31:24] : // R5 R6
                  hit_b2   ? ram_rd[23:16] : // R5
                  hit_b1   ? ram_rd[15:8]  : // R5
                  hit_b0   ? ram_rd[7:0]   : // R5
                  hit_vref ? {2'b00, vref_q} : // R10
                  hit_idx  ? index_q :
                  hit_ctrl ? ctrl_rd : EQR_RD_UNMAPPED;

  // Held reads of the data bytes return zero, as the registers stand in reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= EQR_RD_UNMAPPED;
    end else if (reg_rd) begin
      rdata_q <= (receive_line_hold && (hit_b3 || hit_b2 || hit_b1 || hit_b0)) ? EQR_RST_DATA : rd_sel; // R7
    end else begin
      rdata_q <= EQR_RD_UNMAPPED;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// >>> hw/eqr_pkg.sv
// Package with register map, field layout and reset values for the equalizer RAM access block.
package eqr_pkg;
  localparam logic [7:0] EQR_OFS_BYTE3    = 8'hD8;
  localparam logic [7:0] EQR_OFS_BYTE2    = 8'hD9;
  localparam logic [7:0] EQR_OFS_BYTE1    = 8'hDA;
  localparam logic [7:0] EQR_OFS_BYTE0    = 8'hDB;
  localparam logic [7:0] EQR_OFS_VREF     = 8'hDC;
  localparam logic [7:0] EQR_OFS_INDEX    = 8'hFC;
  localparam logic [7:0] EQR_OFS_CTRL     = 8'hFD;
  localparam logic [7:0] EQR_RST_DATA     = 8'h00;
  localparam logic [5:0] EQR_RST_VREF     = 6'h00;
  localparam logic [7:0] EQR_RST_INDEX    = 8'h00;
  localparam logic [7:0] EQR_RD_UNMAPPED  = 8'h00;
  localparam int         EQR_VREF_W       = 6;
  localparam int         EQR_CTRL_WR_BIT  = 0;
  localparam int         EQR_CTRL_BSY_BIT = 1;
endpackage

// >>> hw/eqr_ram.sv
// Small synchronous memory holding the equalizer coefficient words.
`timescale 1ns/1ps
module eqr_ram
  import eqr_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int DW    = 32
) (
  // Clock.
  input  wire logic          clk,
  // Write port.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data registered.
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_q
);
  logic [DW-1:0] mem [DEPTH];

  // Elaboration-time guard: the address must be able to reach every word.
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_depth_check
    $error("eqr_ram depth exceeds address range");
  end

  // Registered read keeps the output free of combinational memory paths.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule

// >>> verif/eqr_regs_checker.sv
// Port checker for the equalizer RAM register bank.
`timescale 1ns/1ps
module eqr_regs_checker import eqr_pkg::*; #(parameter int DEPTH = 256) (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Register port and line side.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       receive_line_hold,
  input wire logic [5:0] equalizer_reference_field
);
  // Short names keep every property but a_stage_apart on two lines.
  wire       hold = receive_line_hold;
  wire [5:0] lvl  = equalizer_reference_field;
  wire       vw   = reg_wr && reg_addr == EQR_OFS_VREF;
  wire       dat  = reg_addr >= EQR_OFS_BYTE3 && reg_addr <= EQR_OFS_BYTE0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_vref_write: assert property (vw && !hold |=> {2'h0, lvl} == ($past(reg_wdata) & 8'h3F))
    else $error("level write lost");
  a_vref_keep: assert property (!vw && !hold |=> $stable(lvl))
    else $error("level moved");
  a_vref_read: assert property (reg_rd && reg_addr == EQR_OFS_VREF && !hold |=> reg_rdata == {2'h0, $past(lvl)})
    else $error("level readback");
  a_hold_level: assert property (hold |=> lvl == 6'h00)
    else $error("level not held");
  a_hold_data: assert property (reg_rd && hold && dat |=> reg_rdata == 8'h00)
    else $error("data not held");
  a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("stray read data");
  a_unmapped_read: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == EQR_RD_UNMAPPED)
    else $error("unmapped read");
  a_stage_apart: assert property (reg_rd && reg_addr == EQR_OFS_BYTE0 && !hold ##1 !reg_wr
    ##1 reg_wr && reg_addr == EQR_OFS_BYTE0 ##1 !reg_wr
    ##1 reg_rd && reg_addr == EQR_OFS_BYTE0 && !hold |=> reg_rdata == $past(reg_rdata, 4))
    else $error("staging leaked");
  c_vref_write: cover property (vw);
  c_commit: cover property (reg_wr && reg_addr == EQR_OFS_CTRL);
  c_hold_read: cover property (reg_rd && hold && dat);
endmodule
bind eqr_regs eqr_regs_checker #(.DEPTH(DEPTH)) u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .receive_line_hold(receive_line_hold), .equalizer_reference_field(equalizer_reference_field));

// >>> verif/tb_eqr_regs.sv
// Self-checking bench for the equalizer RAM register bank.
`timescale 1ns/1ps
module tb_eqr_regs import eqr_pkg::*;;
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, hold = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, idx;
  wire  [7:0]  reg_rdata;
  wire  [5:0]  lvl;
  logic [31:0] mem [256], stg;
  int          fail_count = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  eqr_regs u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_line_hold(hold), .equalizer_reference_field(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks; strobes drop one edge later so a call is never re-entered at the same edge.
  task chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task op(input logic w, r, input logic [7:0] a, d, e);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (r)
      chk(reg_rdata, e);
  endtask
  task wr(input logic [7:0] a, d);
    op(1'b1, 1'b0, a, d, 8'h00);
  endtask
  task rd(input logic [7:0] a, e);
    op(1'b0, 1'b1, a, 8'h00, e);
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog sized well beyond the roughly 150 cycles the sequence needs.
  initial begin
    #50000;
    fail_count++;
    close_out;
  end
  // Stage, commit and read back random words, then the level register and the hold.
  initial begin
    void'($urandom(32'h5B46DB1A));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(EQR_OFS_VREF, 8'h00);
    rd(8'h00, EQR_RD_UNMAPPED);
    repeat (4) begin
      idx = 8'($urandom);
      stg = $urandom;
      for (int i = 0; i < 4; i++)
        wr(8'(EQR_OFS_BYTE3 + i), stg[31-8*i -: 8]);
      wr(EQR_OFS_INDEX, idx);
      wr(EQR_OFS_CTRL, 8'h01);
      mem[idx] = stg;
      op(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      for (int i = 0; i < 4; i++)
        rd(8'(EQR_OFS_BYTE3 + i), mem[idx][31-8*i -: 8]);
      wr(EQR_OFS_BYTE0, ~stg[7:0]);
      rd(EQR_OFS_BYTE0, mem[idx][7:0]);
    end
    wr(EQR_OFS_VREF, 8'hEC);
    chk({2'h0, lvl}, 8'h2C);
    rd(EQR_OFS_VREF, 8'h2C);
    wr(EQR_OFS_VREF, 8'h34);
    chk({2'h0, lvl}, 8'h34);
    @(posedge clk);
    hold <= 1'b1;
    wr(EQR_OFS_VREF, 8'h2C);
    chk({2'h0, lvl}, 8'h00);
    rd(EQR_OFS_BYTE3, 8'h00);
    wr(EQR_OFS_CTRL, 8'h01);
    @(posedge clk);
    hold <= 1'b0;
    rd(EQR_OFS_VREF, 8'h00);
    rd(EQR_OFS_BYTE3, mem[idx][31:24]);
    rd(EQR_OFS_INDEX, idx);
    // The hold cleared the staging word, so a commit now stores zero.
    wr(EQR_OFS_CTRL, 8'h01);
    mem[idx] = 32'h0000_0000;
    op(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
      rd(8'(EQR_OFS_BYTE3 + i), mem[idx][31-8*i -: 8]);
    close_out;
  end
endmodule
